// File: logic/rct_counter.sv
// Counter and reload byte pair of one timer.
// Assumes ticks, enables and write strobes come from the same clock.
`timescale 1ns/1ps

module rct_counter (
  input  wire logic        ref_clk,    // System clock.
  input  wire logic        rst_n,      // Asynchronous reset, active low.
  input  wire logic        tick_lo,    // Advance the low byte.
  input  wire logic        tick_hi,    // Advance the high byte in split mode.
  input  wire logic        split,      // Two 8-bit counters when set.
  input  wire logic        cap_mode,   // Reload pair holds captures.
  input  wire logic        capture,    // Copy the count into the pair.
  input  wire logic        cnt_lo_we,  // Software write of the low count.
  input  wire logic        cnt_hi_we,  // Software write of the high count.
  input  wire logic        rld_lo_we,  // Software write of the low reload.
  input  wire logic        rld_hi_we,  // Software write of the high reload.
  input  wire logic [7:0]  wdata,      // Byte written by software.
  output logic      [15:0] count,      // Current count, high byte first.
  output logic      [15:0] reload,     // Reload or capture pair.
  output logic             lo_wrap,    // Low byte wraps this cycle.
  output logic             hi_wrap     // High byte or full count wraps.
);

  logic [7:0] cnt_lo_r;   // Low count byte.
  logic [7:0] cnt_hi_r;   // High count byte.
  logic [7:0] rld_lo_r;   // Low reload or capture byte.
  logic [7:0] rld_hi_r;   // High reload or capture byte.
  logic       full_wrap;  // Whole 16-bit count wraps.
  logic       hi_step;    // High byte advances this cycle.

  // ---------------------------------------------------------------
  // Wrap detection
  // ---------------------------------------------------------------
  // The low byte flags a wrap in every mode; the high side wraps alone
  // in split mode and together with the low byte otherwise.
  assign lo_wrap   = tick_lo && (cnt_lo_r == rct_pkg::RCT_BYTE_MAX);
  assign full_wrap = !split && lo_wrap && (cnt_hi_r == rct_pkg::RCT_BYTE_MAX);
  assign hi_step   = split ? tick_hi : lo_wrap;
  assign hi_wrap   = split ? (tick_hi && cnt_hi_r == rct_pkg::RCT_BYTE_MAX)
                           : full_wrap;
  assign count     = {cnt_hi_r, cnt_lo_r};
  assign reload    = {rld_hi_r, rld_lo_r};

  // ---------------------------------------------------------------
  // Low count byte
  // ---------------------------------------------------------------
  // Software writes win over a tick in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_lo_r <= rct_pkg::RCT_BYTE_RST;
    end else if (cnt_lo_we) begin
      cnt_lo_r <= wdata;
    end else if (lo_wrap) begin
      // Reload when this byte's counter portion wraps, unless capturing.
      if (!cap_mode && (split || full_wrap)) begin
        cnt_lo_r <= rld_lo_r;
      end else begin
        cnt_lo_r <= rct_pkg::RCT_BYTE_ZERO;
      end
    end else if (tick_lo) begin
      cnt_lo_r <= cnt_lo_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // High count byte
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_hi_r <= rct_pkg::RCT_BYTE_RST;
    end else if (cnt_hi_we) begin
      cnt_hi_r <= wdata;
    end else if (hi_wrap) begin
      // In capture mode the count simply rolls over to zero.
      cnt_hi_r <= cap_mode ? rct_pkg::RCT_BYTE_ZERO : rld_hi_r;
    end else if (hi_step) begin
      cnt_hi_r <= cnt_hi_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Reload pair
  // ---------------------------------------------------------------
  // A capture wins over a software write in the same cycle so that no
  // event is lost.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rld_lo_r <= rct_pkg::RCT_BYTE_RST;
      rld_hi_r <= rct_pkg::RCT_BYTE_RST;
    end else if (capture) begin
      rld_lo_r <= cnt_lo_r;
      rld_hi_r <= cnt_hi_r;
    end else begin
      if (rld_lo_we) begin
        rld_lo_r <= wdata;
      end
      if (rld_hi_we) begin
        rld_hi_r <= wdata;
      end
    end
  end

endmodule // rct_counter

// File: logic/rct_pkg.sv
// Shared constants and types for the reload/capture timer group.
// Assumes a byte-wide special-function-register bus with paging.
package rct_pkg;

  // ---------------------------------------------------------------
  // Instance layout
  // ---------------------------------------------------------------
  // Index 0 is timer 2, index 1 is timer 3, index 2 is timer 4.
  localparam int RCT_NUM = 3;

  // ---------------------------------------------------------------
  // Register pages and addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] RCT_PAGE_LOW  = 8'h00;  // Shared low page.
  localparam logic [7:0] RCT_PAGE_HIGH = 8'h10;  // Page holding all timers.

  localparam logic [RCT_NUM-1:0][7:0] RCT_ADR_CTRL0 =
    {8'h98, 8'h91, 8'hc8};
  localparam logic [RCT_NUM-1:0][7:0] RCT_ADR_RLD_LO =
    {8'ha2, 8'h92, 8'hca};
  localparam logic [RCT_NUM-1:0][7:0] RCT_ADR_RLD_HI =
    {8'ha3, 8'h93, 8'hcb};
  localparam logic [RCT_NUM-1:0][7:0] RCT_ADR_CNT_LO =
    {8'ha4, 8'h94, 8'hcc};
  localparam logic [RCT_NUM-1:0][7:0] RCT_ADR_CNT_HI =
    {8'ha5, 8'h95, 8'hcd};
  localparam logic [RCT_NUM-1:0][7:0] RCT_ADR_CSEL =
    {8'hff, 8'hfe, 8'hfd};

  // Timers that also decode on the low page.
  localparam logic [RCT_NUM-1:0] RCT_LOW_PAGE_OK = 3'h3;
  // Timers whose control-0 register takes single-bit writes.
  localparam logic [RCT_NUM-1:0] RCT_BIT_ADDR_OK = 3'h5;
  // Mask that turns a bit address into its byte address.
  localparam logic [7:0] RCT_BIT_BYTE_MASK = 8'hf8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RCT_BYTE_RST = 8'h00;
  localparam logic [RCT_NUM-1:0][2:0] RCT_CSEL_RST = {3'h1, 3'h1, 3'h0};

  // ---------------------------------------------------------------
  // Field codes and counting limits
  // ---------------------------------------------------------------
  localparam logic [1:0] RCT_XCLK_EXT  = 2'h1;   // External oscillator / 8.
  localparam logic [2:0] RCT_CAP_PIN   = 3'h0;   // Timer input terminal.
  localparam logic [2:0] RCT_CAP_SLOW  = 3'h1;   // Low-frequency oscillator.
  localparam logic [2:0] RCT_CAP_CMP   = 3'h2;   // Comparator 0 output.
  localparam logic [2:0] RCT_CAP_SOF   = 3'h3;   // Bus start of frame.
  localparam logic [7:0] RCT_BYTE_MAX  = 8'hff;  // Byte wrap point.
  localparam logic [7:0] RCT_BYTE_ZERO = 8'h00;  // Byte after a wrap.

  // System clock divider: a tick every 12 cycles.
  localparam int         RCT_SYS_DIV  = 12;
  localparam logic [3:0] RCT_SYS_LAST = 4'(RCT_SYS_DIV - 1);
  // External oscillator divider: a tick every 8 rising edges.
  localparam int         RCT_EXT_DIV  = 8;
  localparam logic [2:0] RCT_EXT_LAST = 3'(RCT_EXT_DIV - 1);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // One register-bus request; byte and single-bit forms share it.
  typedef struct packed {
    logic [7:0] page;      // Current register page.
    logic [7:0] addr;      // Byte address.
    logic [7:0] wdata;     // Byte write data.
    logic       wr;        // Byte write strobe.
    logic       rd;        // Byte read strobe.
    logic       bit_wr;    // Single-bit write strobe.
    logic [7:0] bit_addr;  // Bit address: byte address plus bit index.
    logic       bit_val;   // Value of the single bit written.
  } rct_sfr_req_t;

  // Layout of each control-0 register, bit 7 first.
  typedef struct packed {
    logic       high_overflow_flag;
    logic       low_overflow_flag;
    logic       low_overflow_irq_enable;
    logic       capture_enable;
    logic       split_mode_select;
    logic       run_control;
    logic [1:0] external_clock_select;
  } rct_ctrl_t;

endpackage

// File: logic/rct_timers.sv
// Three reload/capture timers (timers 2, 3 and 4) behind a paged
// special-function-register bus with single-bit writes.
// Assumes the bus request comes from logic on ref_clk, and that the
// capture and oscillator pins are asynchronous to it.
`timescale 1ns/1ps

module rct_timers (
  input  wire logic                          ref_clk,   // System clock.
  input  wire logic                          rst_n,     // Async reset.
  input  wire rct_pkg::rct_sfr_req_t         sfr_req,   // Bus request.
  output logic      [7:0]                    sfr_rdata, // Read data.
  input  wire logic                          ext_osc,   // External oscillator.
  input  wire logic                          cap_pin,   // Timer input pin.
  input  wire logic                          slow_osc,  // Slow oscillator.
  input  wire logic                          cmp0_out,  // Comparator 0 output.
  input  wire logic                          sof_evt,   // Start-of-frame pulse.
  output logic      [rct_pkg::RCT_NUM-1:0]   irq_req    // Interrupt requests.
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Bit 0 external oscillator, 1 input pin, 2 slow oscillator,
  // 3 comparator; each passes two flip-flops before use.
  localparam int NSYNC = 4;

  logic [NSYNC-1:0] async_in;  // Raw asynchronous inputs.
  logic [NSYNC-1:0] meta_r;    // First synchroniser stage.
  logic [NSYNC-1:0] sync_r;    // Second synchroniser stage.
  logic [NSYNC-1:0] prev_r;    // Previous synchronised level.
  logic [NSYNC-1:0] fall;      // Falling edge seen this cycle.

  assign async_in = {cmp0_out, slow_osc, cap_pin, ext_osc};

  genvar s;
  generate
    for (s = 0; s < NSYNC; s++) begin : g_sync
      // Two-stage synchroniser and edge history for one input.
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[s] <= 1'b0;
          sync_r[s] <= 1'b0;
          prev_r[s] <= 1'b0;
        end else begin
          meta_r[s] <= async_in[s];
          sync_r[s] <= meta_r[s];
          prev_r[s] <= sync_r[s];
        end
      end
      // A high-to-low transition of the synchronised level.
      assign fall[s] = prev_r[s] && !sync_r[s];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Prescalers
  // ---------------------------------------------------------------
  logic [3:0] sys_div_r;  // System clock divide-by-twelve counter.
  logic [2:0] ext_div_r;  // External oscillator divide-by-eight counter.
  logic       sys_tick;   // One cycle in every twelve.
  logic       ext_rise;   // Synchronised oscillator rising edge.
  logic       ext_tick;   // One tick in every eight oscillator edges.

  assign sys_tick = (sys_div_r == rct_pkg::RCT_SYS_LAST);
  assign ext_rise = sync_r[0] && !prev_r[0];
  assign ext_tick = ext_rise && (ext_div_r == rct_pkg::RCT_EXT_LAST);

  // Divide the system clock by twelve.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_div_r <= 4'h0;
    end else if (sys_tick) begin
      sys_div_r <= 4'h0;
    end else begin
      sys_div_r <= sys_div_r + 4'h1;
    end
  end

  // Divide the synchronised external oscillator by eight.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_div_r <= 3'h0;
    end else if (ext_rise) begin
      ext_div_r <= ext_div_r + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Capture sources shared by all timers
  // ---------------------------------------------------------------
  logic pin_evt;   // Falling edge on the timer input pin.
  logic slow_evt;  // Falling edge of the slow oscillator.
  logic cmp_evt;   // Falling edge of the comparator output.

  assign pin_evt  = fall[1];
  assign slow_evt = fall[2];
  assign cmp_evt  = fall[3];

  // ---------------------------------------------------------------
  // Per-timer registers, decode and counter
  // ---------------------------------------------------------------
  // Read contribution of each timer; zero when it is not addressed.
  logic [rct_pkg::RCT_NUM-1:0][7:0] rd_val;
  // Next interrupt request of each timer, from its next flag values.
  logic [rct_pkg::RCT_NUM-1:0]      irq_nxt;

  genvar t;
  generate
    for (t = 0; t < rct_pkg::RCT_NUM; t++) begin : g_tmr
      rct_pkg::rct_ctrl_t ctrl_r;     // Control-0 register.
      rct_pkg::rct_ctrl_t ctrl_nxt;   // Its next value.
      logic [2:0]         csel_r;     // Capture source select field.
      logic               page_ok;    // Current page decodes this timer.
      logic               bit_hit;    // Single-bit write to control-0.
      logic               ctrl_we;    // Byte write to control-0.
      logic               cap_evt;    // Selected capture event.
      logic               capture;    // Capture taken this cycle.
      logic               tick;       // Selected timer clock tick.
      logic               tick_lo;    // Low byte advance.
      logic               tick_hi;    // High byte advance.
      logic               lo_wrap;    // Low byte wrap pulse.
      logic               hi_wrap;    // High byte wrap pulse.
      logic [15:0]        count;      // Current count.
      logic [15:0]        reload;     // Reload pair.

      // Timer 4 sees only the high page; timers 2 and 3 see both.
      assign page_ok = (sfr_req.page == rct_pkg::RCT_PAGE_HIGH) ||
                       (rct_pkg::RCT_LOW_PAGE_OK[t] &&
                        sfr_req.page == rct_pkg::RCT_PAGE_LOW);
      assign ctrl_we = sfr_req.wr && page_ok &&
                       sfr_req.addr == rct_pkg::RCT_ADR_CTRL0[t];
      assign bit_hit = sfr_req.bit_wr && page_ok &&
                       rct_pkg::RCT_BIT_ADDR_OK[t] &&
                       (sfr_req.bit_addr & rct_pkg::RCT_BIT_BYTE_MASK) ==
                       rct_pkg::RCT_ADR_CTRL0[t];

      // Pick the event named by the capture source field.
      always_comb begin
        unique case (csel_r)
          rct_pkg::RCT_CAP_PIN:  cap_evt = pin_evt;
          rct_pkg::RCT_CAP_SLOW: cap_evt = slow_evt;
          rct_pkg::RCT_CAP_CMP:  cap_evt = cmp_evt;
          rct_pkg::RCT_CAP_SOF:  cap_evt = sof_evt;
          default:               cap_evt = 1'b0;
        endcase
      end
      assign capture = ctrl_r.capture_enable && cap_evt;

      // Clock select: external oscillator over eight, else system / 12.
      assign tick = (ctrl_r.external_clock_select ==
                     rct_pkg::RCT_XCLK_EXT) ? ext_tick : sys_tick;
      // In split mode the low byte runs always; run gates the rest.
      assign tick_lo = ctrl_r.split_mode_select ? tick
                       : (tick && ctrl_r.run_control);
      assign tick_hi = tick && ctrl_r.run_control;

      // Next control value: byte write, else bit write, else hold;
      // hardware flag sets always win over a software clear.
      always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_we) begin
          ctrl_nxt = sfr_req.wdata;
        end else if (bit_hit) begin
          ctrl_nxt[sfr_req.bit_addr[2:0]] = sfr_req.bit_val;
        end
        if (lo_wrap) begin
          ctrl_nxt.low_overflow_flag = 1'b1;
        end
        if (hi_wrap || capture) begin
          ctrl_nxt.high_overflow_flag = 1'b1;
        end
      end

      // Control-0 register.
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_r <= rct_pkg::RCT_BYTE_RST;
        end else begin
          ctrl_r <= ctrl_nxt;
        end
      end

      // Capture select; only the low three bits are stored, the
      // reserved bits are kept at their reset value of zero.
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          csel_r <= rct_pkg::RCT_CSEL_RST[t];
        end else if (sfr_req.wr &&
                     sfr_req.page == rct_pkg::RCT_PAGE_HIGH &&
                     sfr_req.addr == rct_pkg::RCT_ADR_CSEL[t]) begin
          csel_r <= sfr_req.wdata[2:0];
        end
      end

      // Counter and reload pair of this timer.
      rct_counter u_cnt (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .tick_lo   (tick_lo),
        .tick_hi   (tick_hi),
        .split     (ctrl_r.split_mode_select),
        .cap_mode  (ctrl_r.capture_enable),
        .capture   (capture),
        .cnt_lo_we (sfr_req.wr && page_ok &&
                    sfr_req.addr == rct_pkg::RCT_ADR_CNT_LO[t]),
        .cnt_hi_we (sfr_req.wr && page_ok &&
                    sfr_req.addr == rct_pkg::RCT_ADR_CNT_HI[t]),
        .rld_lo_we (sfr_req.wr && page_ok &&
                    sfr_req.addr == rct_pkg::RCT_ADR_RLD_LO[t]),
        .rld_hi_we (sfr_req.wr && page_ok &&
                    sfr_req.addr == rct_pkg::RCT_ADR_RLD_HI[t]),
        .wdata     (sfr_req.wdata),
        .count     (count),
        .reload    (reload),
        .lo_wrap   (lo_wrap),
        .hi_wrap   (hi_wrap)
      );

      // Read value of this timer at the requested address.
      always_comb begin
        rd_val[t] = 8'h00;
        if (page_ok && sfr_req.addr == rct_pkg::RCT_ADR_CTRL0[t]) begin
          rd_val[t] = ctrl_r;
        end else if (page_ok &&
                     sfr_req.addr == rct_pkg::RCT_ADR_RLD_LO[t]) begin
          rd_val[t] = reload[7:0];
        end else if (page_ok &&
                     sfr_req.addr == rct_pkg::RCT_ADR_RLD_HI[t]) begin
          rd_val[t] = reload[15:8];
        end else if (page_ok &&
                     sfr_req.addr == rct_pkg::RCT_ADR_CNT_LO[t]) begin
          rd_val[t] = count[7:0];
        end else if (page_ok &&
                     sfr_req.addr == rct_pkg::RCT_ADR_CNT_HI[t]) begin
          rd_val[t] = count[15:8];
        end else if (sfr_req.page == rct_pkg::RCT_PAGE_HIGH &&
                     sfr_req.addr == rct_pkg::RCT_ADR_CSEL[t]) begin
          rd_val[t] = {5'h00, csel_r};
        end
      end

      // Request while the high flag, or the enabled low flag, is set.
      assign irq_nxt[t] = ctrl_nxt.high_overflow_flag ||
                          (ctrl_nxt.low_overflow_flag &&
                           ctrl_nxt.low_overflow_irq_enable);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data and interrupt outputs
  // ---------------------------------------------------------------
  logic [7:0] rd_any;  // OR of all timer read values.

  // Addresses never overlap, so an OR of the per-timer values selects.
  always_comb begin
    rd_any = 8'h00;
    for (int i = 0; i < rct_pkg::RCT_NUM; i++) begin
      rd_any = rd_any | rd_val[i];
    end
  end

  // Read data is taken on the read strobe and held until the next one;
  // unmapped addresses read as zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= rct_pkg::RCT_BYTE_RST;
    end else if (sfr_req.rd) begin
      sfr_rdata <= rd_any;
    end
  end

  // Interrupt requests follow the flag registers in the same edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= irq_nxt;
    end
  end

endmodule // rct_timers

// File: tb/rct_timers_sva.sv
// Checker for the timer group's register port and interrupt lines.
// Assumes it is bound to rct_timers and sees only that module's ports.
`timescale 1ns/1ps
module rct_timers_chk (
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire rct_pkg::rct_sfr_req_t       sfr_req,
  input wire logic [7:0]                  sfr_rdata,
  input wire logic [rct_pkg::RCT_NUM-1:0] irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic rd_w = sfr_req.rd;             // Read strobe.
  wire logic p10  = sfr_req.page == 8'h10;  // High page selected.
  read_hold_a: assert property (!rd_w |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rd_w && sfr_req.addr == 8'h80
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  t4_page_a: assert property (rd_w && sfr_req.page == 8'h00 &&
    sfr_req.addr inside {8'h98, 8'ha2, 8'ha3, 8'ha4, 8'ha5}
    |=> sfr_rdata == 8'h00) else $error("timer 4 seen on low page");
  csel_resv_a: assert property (rd_w && p10 &&
    sfr_req.addr inside {8'hfd, 8'hfe, 8'hff}
    |=> sfr_rdata[7:3] == 5'h00) else $error("reserved select bits set");
  reload_wr_a: assert property (sfr_req.wr && sfr_req.addr == 8'hca
    && sfr_req.page inside {8'h00, 8'h10}
    ##1 rd_w && !sfr_req.wr && sfr_req.addr == 8'hca
    |=> sfr_rdata == $past(sfr_req.wdata, 2)) else $error("reload lost");
  bit_wr_a: assert property (sfr_req.bit_wr && p10 &&
    sfr_req.bit_addr == 8'h9d ##1 rd_w && p10 && sfr_req.addr == 8'h98
    |=> sfr_rdata[5] == $past(sfr_req.bit_val, 2))
    else $error("single-bit write lost");
  sw_clear_a: assert property ($fell(irq_req[1]) |->
    $past(sfr_req.wr) || $past(sfr_req.wr, 2))
    else $error("flag cleared without software");
  irq_rst_a: assert property ($rose(rst_n) |-> irq_req == '0)
    else $error("interrupt raised out of reset");
  bit_cv: cover property (sfr_req.bit_wr);
  cap_cv: cover property ($rose(irq_req[0]));
  ovf_cv: cover property ($rose(irq_req[1]));
  ext_cv: cover property ($rose(irq_req[2]));
endmodule // rct_timers_chk
bind rct_timers rct_timers_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .irq_req(irq_req));

// File: tb/rct_timers_tb.sv
// Self-checking bench for the three reload/capture timers.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module rct_timers_tb;
  logic ref_clk, rst_n, ext_osc, cap_pin, slow_osc, cmp0_out, sof_evt;
  rct_pkg::rct_sfr_req_t req;  // Register bus request.
  logic [7:0] sfr_rdata;       // Read data.
  logic [2:0] irq_req;         // Interrupt lines.
  int bad_count, checked, cycles;
  logic [7:0] ra [18] = '{8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h98,
    8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd,
    8'hfd, 8'hfe, 8'hff};
  rct_timers DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(req),
    .sfr_rdata(sfr_rdata), .ext_osc(ext_osc), .cap_pin(cap_pin),
    .slow_osc(slow_osc), .cmp0_out(cmp0_out), .sof_evt(sof_evt),
    .irq_req(irq_req));
  always #20 ref_clk = ~ref_clk;
  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask
  // One bus cycle, launched at a falling edge; strobes hold until next op.
  task automatic op(input logic w, r, b, input logic [7:0] p, a, d);
    req = '{p, a, d, w, r, b, a, d[0]};
    @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] p, a, d);
    op(1'b1, 1'b0, 1'b0, p, a, d);
  endtask
  task automatic rd(input logic [7:0] p, a, e);
    op(1'b0, 1'b1, 1'b0, p, a, 8'h00);
    chk(sfr_rdata, e);
  endtask
  task automatic idle(input int n);
    op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    repeat (n) @(negedge ref_clk);
  endtask
  // Drops one capture source for a cycle; for source 3 it raises the start-of-frame pulse instead.
  task automatic pulse(input int s);
    case (s)
      0: cap_pin = 1'b0;
      1: slow_osc = 1'b0;
      2: cmp0_out = 1'b0;
      default: sof_evt = 1'b1;
    endcase
    @(negedge ref_clk);
    {cap_pin, slow_osc, cmp0_out, sof_evt} = 4'he;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {ref_clk, rst_n, ext_osc, req} = '0;
    {cap_pin, slow_osc, cmp0_out, sof_evt} = 4'he;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    // Reset values: only the timer 3 and 4 selects come up as one.
    foreach (ra[i]) rd(8'h10, ra[i], (ra[i] >= 8'hfe) ? 8'h01 : 8'h00);
    rd(8'h00, 8'h80, 8'h00);
    wr(8'h00, 8'ha2, 8'h55);
    rd(8'h10, 8'ha2, 8'h00);
    rd(8'h00, 8'ha4, 8'h00);
    wr(8'h00, 8'hca, 8'h3c);
    rd(8'h10, 8'hca, 8'h3c);
    op(1'b0, 1'b0, 1'b1, 8'h10, 8'h9d, 8'h01);
    rd(8'h10, 8'h98, 8'h20);
    // Timer 4 is hidden on the low page, even from single-bit writes.
    op(1'b0, 1'b0, 1'b1, 8'h00, 8'h9d, 8'h00);
    rd(8'h00, 8'h98, 8'h00);
    rd(8'h10, 8'h98, 8'h20);
    // Full count 0xfffe runs through its wrap and reloads 0x12fe.
    wr(8'h00, 8'h92, 8'hfe);
    wr(8'h00, 8'h93, 8'h12);
    wr(8'h00, 8'h94, 8'hfe);
    wr(8'h00, 8'h95, 8'hff);
    wr(8'h00, 8'h91, 8'h04);
    idle(32);
    chk({7'h00, irq_req[1]}, 8'h01);
    wr(8'h00, 8'h91, 8'h00);
    rd(8'h00, 8'h95, 8'h12);
    idle(2);
    chk({7'h00, irq_req[1]}, 8'h00);
    wr(8'h00, 8'h94, 8'h40);
    idle(30);
    rd(8'h00, 8'h94, 8'h40);
    // Split mode with run off: only the low byte moves and wraps.
    wr(8'h00, 8'h95, 8'h05);
    wr(8'h00, 8'h94, 8'hff);
    wr(8'h00, 8'h91, 8'h08);
    idle(14);
    rd(8'h00, 8'h95, 8'h05);
    rd(8'h00, 8'h91, 8'h48);
    // Every capture source copies the held count into timer 2's pair.
    wr(8'h00, 8'hc8, 8'h10);
    for (int s = 0; s < 4; s++) begin
      wr(8'h10, 8'hfd, 8'(s));
      wr(8'h00, 8'hcd, 8'h34);
      wr(8'h00, 8'hcc, 8'(s + 8));
      idle(1);
      pulse(s);
      idle(6);
      rd(8'h00, 8'hca, 8'(s + 8));
      rd(8'h00, 8'hcb, 8'h34);
    end
    chk({7'h00, irq_req[0]}, 8'h01);
    // Timer 4 on the external clock: one tick per eight oscillator rises.
    wr(8'h10, 8'ha4, 8'hfe);
    wr(8'h10, 8'h98, 8'h25);
    for (int k = 0; k < 16; k++) begin
      ext_osc = 1'b1;
      idle(1);
      ext_osc = 1'b0;
      idle(1);
      if (k == 7) rd(8'h10, 8'ha4, 8'hff);
    end
    rd(8'h10, 8'ha4, 8'h00);
    rd(8'h10, 8'h98, 8'h65);
    chk({7'h00, irq_req[2]}, 8'h01);
    report_and_stop();
  end
endmodule // rct_timers_tb
